// *** design/adcr_defs.svh ***
// register offsets, field positions, reset values and timing counts for the converter control
// assumes inclusion by the control block and its bench; definitions only
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH
// byte offsets on the apb slave
`define ADCR_OFF_CSR 12'h000
`define ADCR_OFF_RH 12'h004
`define ADCR_OFF_RL 12'h008
`define ADCR_OFF_CLK 12'h00c
// control/status fields
`define ADCR_CSR_DONE 7
`define ADCR_CSR_IEN 6
`define ADCR_CSR_CONT 5
`define ADCR_CH_HI 4
`define ADCR_CH_LO 0
// clock config fields
`define ADCR_CLK_DIV_HI 7
`define ADCR_CLK_DIV_LO 5
`define ADCR_CLK_SRC 4
`define ADCR_CLK_MODE_HI 3
`define ADCR_CLK_MODE_LO 2
// reset values: channels all ones (converter off), right justified, crystal source
`define ADCR_CSR_RST 8'h1f
`define ADCR_CLK_RST 8'h04
// channel codes
`define ADCR_CH_EXT_MAX 5'h07
`define ADCR_CH_UPPER_REFERENCE 5'h1d
`define ADCR_CH_LOWER_REFERENCE 5'h1e
`define ADCR_CH_OFF 5'h1f
// converter clock cycles per conversion: 16 sampling/approx, the code captured on the 16th tick
`define ADCR_CONV_CYCLES 5'h10
`define ADCR_ZERO8 8'h00
`endif

// *** design/adcr_pkg.sv ***
// types for the converter control block
// assumes the defines header is compiled alongside
package adcr_pkg;
	// justification modes, encoded as the two mode bits
	typedef enum logic [1:0] {
		ADCR_TRUNC8 = 2'h0,
		ADCR_RIGHT = 2'h1,
		ADCR_LEFT = 2'h2,
		ADCR_LEFT_SGN = 2'h3
	} adcr_mode_t;
	// conversion sequencer states, one-hot
	typedef enum logic [2:0] {
		ADCR_IDLE = 3'h1,
		ADCR_CONV = 3'h2,
		ADCR_DONE = 3'h4
	} adcr_state_t;
endpackage

// *** design/adcr_ctrl.sv ***
// converter control: apb registers, clock divider, sequencer, result formatting
// assumes an external analog core sampling channel and start on the converter tick,
// returning a 10-bit code that is valid when the sequence ends
`timescale 1ns/1ps
`include "adcr_defs.svh"
module adcr_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_clock,
	input wire logic [9:0] core_result,
	output logic [4:0] core_channel,
	output logic core_start,
	output logic core_tick,
	output logic core_power_off,
	output logic done_irq
);
	// register state
	logic [7:0] csr_r; // enable, continuous, channel (done bit held separately)
	logic [7:0] clk_r; // divider, source, mode
	logic done_r; // completion flag
	logic [7:0] res_hi_r; // formatted high result
	logic [7:0] res_lo_r; // formatted low result
	logic lo_frozen_r; // high read, low pending
	logic [9:0] raw_r; // captured code
	adcr_pkg::adcr_state_t state_r;
	logic [4:0] cnt_r; // converter cycles left
	logic [3:0] div_r; // prescale counter
	logic xtal_d_r; // crystal level of last cycle
	logic tick_r; // one-cycle converter clock tick
	logic pend_r; // conversion requested
	// bus decode
	logic acc, wr, rd;
	logic wr_csr, wr_clk, rd_rh, rd_rl;
	logic addr_ok;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign wr_csr = wr & (paddr == `ADCR_OFF_CSR);
	assign wr_clk = wr & (paddr == `ADCR_OFF_CLK);
	assign rd_rh = rd & (paddr == `ADCR_OFF_RH);
	assign rd_rl = rd & (paddr == `ADCR_OFF_RL);
	assign addr_ok = (paddr == `ADCR_OFF_CSR) | (paddr == `ADCR_OFF_RH) |
		(paddr == `ADCR_OFF_RL) | (paddr == `ADCR_OFF_CLK);
	// field views
	logic [4:0] chan;
	logic ien, cont;
	logic [2:0] divsel;
	logic src_bus;
	adcr_pkg::adcr_mode_t mode;
	assign chan = csr_r[`ADCR_CH_HI:`ADCR_CH_LO];
	assign ien = csr_r[`ADCR_CSR_IEN];
	assign cont = csr_r[`ADCR_CSR_CONT];
	assign divsel = clk_r[`ADCR_CLK_DIV_HI:`ADCR_CLK_DIV_LO];
	assign src_bus = clk_r[`ADCR_CLK_SRC];
	assign mode = adcr_pkg::adcr_mode_t'(clk_r[`ADCR_CLK_MODE_HI:`ADCR_CLK_MODE_LO]);
	logic powered;
	assign powered = (chan != `ADCR_CH_OFF);
	// control/status register; done bit position ignored on write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_r <= `ADCR_CSR_RST;
		end else if (wr_csr) begin
			csr_r <= {1'b0, pwdata[6:0]};
		end
	end
	// clock config register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_r <= `ADCR_CLK_RST;
		end else if (wr_clk) begin
			clk_r <= pwdata[7:0];
		end
	end
	// input clock: bus clock every cycle, or a rising edge of the crystal
	logic src_edge;
	assign src_edge = src_bus ? 1'b1 : (crystal_clock & ~xtal_d_r);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_d_r <= 1'b0;
		end else begin
			xtal_d_r <= crystal_clock;
		end
	end
	// prescaler: ratio minus one chosen by divider select
	logic [3:0] div_max;
	always_comb begin
		div_max = 4'hf;
		if (!divsel[2]) begin
			unique case (divsel[1:0])
				2'h0: div_max = 4'h0;
				2'h1: div_max = 4'h1;
				2'h2: div_max = 4'h3;
				2'h3: div_max = 4'h7;
			endcase
		end
	end
	// tick generator; held still while powered off to save switching
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 4'h0;
			tick_r <= 1'b0;
		end else if (!powered) begin
			div_r <= 4'h0;
			tick_r <= 1'b0;
		end else if (src_edge) begin
			div_r <= (div_r >= div_max) ? 4'h0 : div_r + 4'h1;
			tick_r <= (div_r >= div_max);
		end else begin
			tick_r <= 1'b0;
		end
	end
	// request latch: a csr write asks for a fresh conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= 1'b0;
		end else if (wr_csr) begin
			pend_r <= 1'b1;
		end else if (tick_r && state_r == adcr_pkg::ADCR_IDLE) begin
			pend_r <= 1'b0;
		end
	end
	// sequencer; a csr write aborts, the latched request restarts on the next tick
	logic conv_end;
	assign conv_end = (state_r == adcr_pkg::ADCR_DONE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= adcr_pkg::ADCR_IDLE;
			cnt_r <= 5'h00;
		end else if (wr_csr || !powered) begin
			state_r <= adcr_pkg::ADCR_IDLE;
			cnt_r <= 5'h00;
		end else begin
			unique case (state_r)
				adcr_pkg::ADCR_IDLE: begin
					// start waits for a tick, giving 16 to 17 converter cycles overall
					if (tick_r && pend_r) begin
						state_r <= adcr_pkg::ADCR_CONV;
						cnt_r <= `ADCR_CONV_CYCLES;
					end
				end
				adcr_pkg::ADCR_CONV: begin
					if (tick_r) begin
						cnt_r <= cnt_r - 5'h01;
						if (cnt_r == 5'h01) begin
							state_r <= adcr_pkg::ADCR_DONE;
						end
					end
				end
				adcr_pkg::ADCR_DONE: begin
					// continuous mode rearms straight away
					state_r <= cont ? adcr_pkg::ADCR_CONV : adcr_pkg::ADCR_IDLE;
					cnt_r <= cont ? `ADCR_CONV_CYCLES : 5'h00;
				end
			endcase
		end
	end
	// core handshake, registered on the bus clock every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_channel <= `ADCR_CH_OFF;
			core_start <= 1'b0;
			core_tick <= 1'b0;
			core_power_off <= 1'b1;
		end else begin
			// codes 0-7 external, 1d/1e references; others pass, result undefined
			core_channel <= chan;
			// continuous mode needs its own strobe, or the core would never sample again
			core_start <= !wr_csr && powered &&
				((tick_r && pend_r && state_r == adcr_pkg::ADCR_IDLE) || (conv_end && cont));
			core_tick <= tick_r;
			core_power_off <= !powered;
		end
	end
	// raw capture at completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_r <= 10'h000;
		end else if (state_r == adcr_pkg::ADCR_CONV && tick_r && cnt_r == 5'h01) begin
			raw_r <= core_result;
		end
	end
	// formatting of the captured code
	logic [7:0] fmt_hi, fmt_lo;
	always_comb begin
		fmt_hi = `ADCR_ZERO8;
		fmt_lo = `ADCR_ZERO8;
		unique case (mode)
			adcr_pkg::ADCR_TRUNC8: begin
				fmt_lo = raw_r[9:2];
			end
			adcr_pkg::ADCR_RIGHT: begin
				fmt_hi = {6'h00, raw_r[9:8]};
				fmt_lo = raw_r[7:0];
			end
			adcr_pkg::ADCR_LEFT: begin
				fmt_hi = raw_r[9:2];
				fmt_lo = {raw_r[1:0], 6'h00};
			end
			adcr_pkg::ADCR_LEFT_SGN: begin
				fmt_hi = {~raw_r[9], raw_r[8:2]};
				fmt_lo = {raw_r[1:0], 6'h00};
			end
		endcase
	end
	// interlock: in ten-bit modes a high read freezes low until low is read
	logic ten_bit;
	assign ten_bit = (mode != adcr_pkg::ADCR_TRUNC8);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_frozen_r <= 1'b0;
		end else if (rd_rl || !ten_bit) begin
			lo_frozen_r <= 1'b0;
		end else if (rd_rh) begin
			lo_frozen_r <= 1'b1;
		end
	end
	// result update; results during an open interlock are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_hi_r <= `ADCR_ZERO8;
			res_lo_r <= `ADCR_ZERO8;
		end else if (conv_end && !(lo_frozen_r && ten_bit)) begin
			res_hi_r <= fmt_hi;
			res_lo_r <= fmt_lo;
		end
	end
	// done flag; set wins over a same-cycle read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else if (ien) begin
			done_r <= 1'b0;
		end else if (conv_end) begin
			done_r <= 1'b1;
		end else if (rd_rh || rd_rl) begin
			done_r <= 1'b0;
		end
	end
	// interrupt request; end of conversion wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_irq <= 1'b0;
		end else if (!ien) begin
			done_irq <= 1'b0;
		end else if (conv_end) begin
			done_irq <= 1'b1;
		end else if (rd_rh || rd_rl || wr_csr) begin
			done_irq <= 1'b0;
		end
	end
	// read mux, registered on the setup cycle so the access phase has one wait-free answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`ADCR_OFF_CSR: prdata <= {24'h000000, done_r & ~ien, csr_r[6:0]};
					`ADCR_OFF_RH: prdata <= {24'h000000, res_hi_r};
					`ADCR_OFF_RL: prdata <= {24'h000000, res_lo_r};
					`ADCR_OFF_CLK: prdata <= {24'h000000, clk_r};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
	// checks
	a_irq_done_excl: assert property (@(posedge pclk) disable iff (!presetn)
		!(done_irq && done_r)) else $error("done flag and irq both set");
	a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && !ien |=> done_r) else $error("done flag not set");
	a_irq_sets: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && ien |=> done_irq) else $error("irq not raised");
	a_irq_drops: assert property (@(posedge pclk) disable iff (!presetn)
		wr_csr && !conv_end |=> !done_irq) else $error("irq not dropped");
	a_freeze_low: assert property (@(posedge pclk) disable iff (!presetn)
		lo_frozen_r && ten_bit && !rd_rl |=> $stable(res_lo_r)) else $error("low moved");
	a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
		wr_csr |=> state_r == adcr_pkg::ADCR_IDLE) else $error("no abort");
	a_off_power: assert property (@(posedge pclk) disable iff (!presetn)
		chan == `ADCR_CH_OFF |=> core_power_off && !tick_r) else $error("not off");
	a_trunc_high: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && mode == adcr_pkg::ADCR_TRUNC8 |=> res_hi_r == `ADCR_ZERO8)
		else $error("high not zero");
	a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && !cont && !wr_csr |=> state_r == adcr_pkg::ADCR_IDLE)
		else $error("single mode repeated");
	// flag masking, sequencing, capture and formatting
	// the capture check ties the registered code to the core output one edge earlier
	a_ien_masks: assert property (@(posedge pclk) disable iff (!presetn)
		ien |=> !done_r) else $error("done flag set with irq enabled");
	a_cont_restart: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && cont && powered && !wr_csr
		|=> core_start && state_r == adcr_pkg::ADCR_CONV) else $error("no continuous restart");
	a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!powered |=> state_r == adcr_pkg::ADCR_IDLE) else $error("conversion while off");
	a_raw_capture: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == adcr_pkg::ADCR_CONV && tick_r && cnt_r == 5'h01
		|=> raw_r == $past(core_result)) else $error("result not captured");
	a_right_high: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && mode == adcr_pkg::ADCR_RIGHT && !lo_frozen_r |=> res_hi_r[7:2] == 6'h00)
		else $error("right high not clear");
	a_start_fresh: assert property (@(posedge pclk) disable iff (!presetn)
		wr_csr |=> pend_r) else $error("write did not request a conversion");
endmodule

// *** testbench/adcr_core_model.sv ***
// analog core stand-in: latches one code per conversion start
// assumes the control block drives channel, start and power-off on pclk
`timescale 1ns/1ps
module adcr_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [4:0] core_channel,
	input wire logic core_start,
	input wire logic core_power_off,
	input wire logic [9:0] sample,
	output logic [9:0] core_result
);
	logic [9:0] held_r; // code of the running conversion
	logic valid_r; // code valid until power-off
	logic [9:0] junk_r; // garbage that changes every cycle
	// latch at start; fixed references, unused codes give garbage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_r <= 10'h000;
			valid_r <= 1'b0;
			junk_r <= 10'h155;
		end else begin
			junk_r <= ~junk_r + 10'h001;
			if (core_power_off) begin
				valid_r <= 1'b0;
			end else if (core_start) begin
				valid_r <= 1'b1;
				if (core_channel <= 5'h07) held_r <= sample;
				else if (core_channel == 5'h1d) held_r <= 10'h3ff;
				else if (core_channel == 5'h1e) held_r <= 10'h000;
				else held_r <= junk_r;
			end
		end
	end
	// garbage until a start after reset or power-off, so a sample taken without a start is caught
	assign core_result = valid_r ? held_r : junk_r;
endmodule

// *** testbench/testbench.sv ***
// bench for the converter control: apb traffic, core stand-in, result checks
// assumes adcr_ctrl, adcr_pkg and the core model are compiled before it
`timescale 1ns/1ps
`include "adcr_defs.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic crystal_clock = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [9:0] sample = 10'h000; // level seen by the core stand-in
	logic [31:0] prdata, rd, r;
	logic pready, pslverr, serr;
	logic [9:0] core_result;
	logic [4:0] core_channel;
	logic core_start, core_tick, core_power_off, done_irq;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'h68d3776b;
	int g;
	always #25 pclk = ~pclk;
	logic [1:0] xtal_cnt = 2'h0; // crystal phase counter
	// crystal at a quarter of the bus rate, driven like every other input
	always @(posedge pclk) begin
		xtal_cnt <= xtal_cnt + 2'h1;
		crystal_clock <= xtal_cnt[1];
	end
	adcr_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .crystal_clock, .core_result, .core_channel, .core_start,
		.core_tick, .core_power_off, .done_irq);
	adcr_core_model i_core (.pclk, .presetn, .core_channel, .core_start, .core_power_off,
		.sample, .core_result);
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, well above the expected run
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; an idle edge after it avoids double drives
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no fixed wait assumed; the hang guard ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		chk("pready", 1, pready);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// polls status until done flag or interrupt shows
	task automatic wait_done(input logic irq);
		int n;
		n = 0;
		do begin
			apb(1'b0, `ADCR_OFF_CSR, 8'h00);
			n++;
		end while ((irq ? done_irq : rd[7]) !== 1'b1 && n < 300);
		chk("conversion end", 1, n < 300);
	endtask
	task automatic tick_gap(output int gap);
		int n;
		n = 0;
		while (core_tick !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		gap = 0;
		do begin
			@(posedge pclk);
			gap++;
		end while (core_tick !== 1'b1 && gap < 100);
	endtask
	// expected {result_high, result_low} per justification mode
	function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
		case (m)
			2'h0: return {8'h00, v[9:2]};
			2'h1: return {6'h00, v};
			2'h2: return {v[9:2], v[1:0], 6'h00};
			default: return {~v[9], v[8:2], v[1:0], 6'h00};
		endcase
	endfunction
	// one single conversion on the bus clock, results read high then low
	task automatic conv(input logic [1:0] m, input logic [4:0] ch, input logic [9:0] v);
		logic [15:0] e;
		sample <= v;
		apb(1'b1, `ADCR_OFF_CLK, {4'h1, m, 2'h0});
		apb(1'b1, `ADCR_OFF_CSR, {3'h0, ch});
		wait_done(1'b0);
		e = fmt(m, ch == 5'h1d ? 10'h3ff : ch == 5'h1e ? 10'h000 : v);
		chk("core channel", ch, core_channel);
		apb(1'b0, `ADCR_OFF_RH, 8'h00);
		chk("result high", e[15:8], rd);
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		chk("result low", e[7:0], rd);
		apb(1'b0, `ADCR_OFF_CSR, 8'h00);
		chk("done cleared", ch, rd);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `ADCR_OFF_CSR, 8'h00);
		chk("status reset", 8'h1f, rd);
		apb(1'b0, `ADCR_OFF_CLK, 8'h00);
		chk("clock reset", 8'h04, rd);
		chk("power off", 1, core_power_off);
		apb(1'b1, 12'h010, 8'h55);
		chk("slave error", 1, serr);
		// first conversion after power-up is thrown away; low read clears the flag
		apb(1'b1, `ADCR_OFF_CLK, 8'h14);
		apb(1'b1, `ADCR_OFF_CSR, 8'h00);
		wait_done(1'b0);
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			conv(2'(i), {2'h0, r[12:10]}, r[9:0]);
		end
		conv(2'h3, 5'h1d, 10'h000);
		conv(2'h1, 5'h1e, 10'h3ff);
		conv(2'h0, 5'h07, 10'h3ff);
		conv(2'h2, 5'h00, 10'h000);
		repeat (60) @(posedge pclk);
		apb(1'b0, `ADCR_OFF_CSR, 8'h00);
		chk("single shot", 0, rd);
		// interrupt mode: timing, flag masked, drop on read and on write
		apb(1'b1, `ADCR_OFF_CSR, 8'h5d);
		g = 0;
		while (done_irq !== 1'b1 && g < 100) begin
			@(posedge pclk);
			g++;
		end
		chk("conversion cycles", 1, g >= 16 && g <= 20);
		apb(1'b0, `ADCR_OFF_CSR, 8'h00);
		chk("flag with irq", 8'h5d, rd);
		// low read: a lone high read here would leave the interlock closed
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		chk("irq after read", 0, done_irq);
		apb(1'b1, `ADCR_OFF_CSR, 8'h40);
		wait_done(1'b1);
		apb(1'b1, `ADCR_OFF_CSR, 8'h5f);
		chk("irq after write", 0, done_irq);
		@(posedge pclk);
		chk("power off", 1, core_power_off);
		// continuous, right justified: high read freezes low
		r = $random(seed);
		sample <= r[9:0];
		apb(1'b1, `ADCR_OFF_CLK, 8'h14);
		apb(1'b1, `ADCR_OFF_CSR, 8'h20);
		wait_done(1'b0);
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		wait_done(1'b0);
		apb(1'b0, `ADCR_OFF_RH, 8'h00);
		chk("result high", r[9:8], rd);
		sample <= ~r[9:0];
		repeat (80) @(posedge pclk);
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		chk("frozen low", r[7:0], rd);
		// slow divider: a rewrite mid-conversion must restart it
		apb(1'b1, `ADCR_OFF_CLK, 8'h94);
		apb(1'b1, `ADCR_OFF_CSR, 8'h1d);
		// clear a flag left by the continuous run so only the restart can set it
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		repeat (40) @(posedge pclk);
		apb(1'b1, `ADCR_OFF_CSR, 8'h1e);
		wait_done(1'b0);
		apb(1'b0, `ADCR_OFF_RL, 8'h00);
		chk("restarted low", 0, rd);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, `ADCR_OFF_CLK, {3'(c), 5'h14});
			tick_gap(g);
			tick_gap(g);
			chk("tick spacing", c > 3 ? 16 : 1 << c, g);
		end
		apb(1'b1, `ADCR_OFF_CLK, 8'h04);
		tick_gap(g);
		tick_gap(g);
		chk("crystal spacing", 4, g);
		final_report();
	end
endmodule
